/* File: inc/imw_pkg.sv */
// constants and types of the two-wire margin and supervision command slave
package imw_pkg;
    localparam logic [4:0] IMW_ADDR_FIXED = 5'h1d;
    localparam logic [2:0] IMW_FLD_MARGIN = 3'h1;
    localparam logic [2:0] IMW_FLD_SUP = 3'h3;
    localparam logic [4:0] IMW_VAL_GUARD = 5'h00;
    localparam int IMW_TGT_BIT = 4;
    localparam int IMW_WIN_BIT = 2;
    localparam logic [3:0] IMW_MARGIN_NOMINAL = 4'h0;
    localparam logic [3:0] IMW_MARGIN_UNDEF = 4'hf;
    localparam logic [1:0] IMW_SUP_EN_CODE = 2'h1;
    localparam logic [1:0] IMW_PERIOD_RST = 2'h0;
    localparam logic [3:0] IMW_LAST_BIT = 4'h7;
    localparam logic [3:0] IMW_ACK_BIT = 4'h8;
    localparam logic [2:0] IMW_STRAP_SETTLE = 3'h4;

    typedef enum {
        LNK_IDLE,
        LNK_ADDR,
        LNK_DATA
    } imw_link_state_type;

    typedef enum {
        GRD_NONE,
        GRD_MARGIN,
        GRD_SUP
    } imw_guard_type;

    typedef struct packed {
        logic is_start;
        logic [7:0] data;
    } imw_evt_type;

    typedef struct packed {
        logic enable;
        logic window;
        logic [1:0] period;
    } imw_sup_type;
endpackage

/* File: verilog/imw_slave.sv */
// write-only two-wire slave for output margining and supervision timer setup
// Summary of operation
// - transfer opens with start, address, direction
// - acknowledge own address
// - address bits 6..2 fixed at 11101
// - address bits 1..0 follow the two straps
// - mode strap picks oscillator pin direction
// - acknowledge every data byte after address
// - byte splits into 3-bit field, 5-bit value
// - field 001 margining, 011 supervision timer
// - operative byte needs matching guard byte first
// - value bit 4 picks linear or switching
// - low four bits pick offset in percent
// - codes 01xxx enable timer, window, period
// - supervision guard twice stops the timer
// - command in open window restarts timer
// - stop ends transfer, device goes idle
module imw_slave (
    input wire logic clk_in, // 20 MHz system clock
    input wire logic reset_in, // async reset, active high
    input wire logic scl_in, // serial clock, link domain
    input wire logic sda_in, // serial data level
    output logic sda_out, // serial data drive value
    output logic sda_oe_out, // serial data drive enable
    input wire logic oscillator_mode_strap_in, // strap, high when open
    input wire logic addr_strap_in, // low address strap
    input wire logic osc_ref_in, // internal oscillator level
    input wire logic osc_sync_pin_in, // sync pin level
    output logic osc_sync_pin_out, // sync pin drive value
    output logic osc_sync_pin_oe_out, // sync pin drive enable
    output logic ext_sync_out, // filtered external sync
    output logic [3:0] linear_margin_out, // linear output offset
    output logic [3:0] switching_margin_out, // switching output offset
    output imw_pkg::imw_sup_type sup_cfg_out, // timer settings
    output logic sup_restart_out, // timer clear pulse
    input wire logic sup_window_open_in, // timer window open
    output logic bus_active_out // start seen, no stop yet
);
    import imw_pkg::*;

    localparam int NSYNC = 5;

    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] sync1_q, sync2_q, sync3_q, filt_q;
    logic [2:0] settle_q;
    logic strap_done_q;
    logic [1:0] sel_q;
    logic [1:0] sel_m_q, sel_s_q;
    logic start_tog_q, stop_tog_q, start_seen_q, start_hit_q;
    logic ack_drive_q, ack_q, evt_tog_q;
    imw_link_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] byte_w;
    logic addr_match;
    imw_evt_type evt_q;
    logic evt_seen_q, stop_seen_q, evt_new, stop_new;
    logic [2:0] fld;
    logic [4:0] val;
    logic is_byte, is_guard, mar_cmd, sup_cmd, sup_ok, sup_off;
    imw_guard_type guard_q;
    imw_sup_type sup_q;

    // ---------------- system domain: pin filters and straps
    assign raw_pins = {evt_tog_q, stop_tog_q, osc_sync_pin_in,
                       oscillator_mode_strap_in, addr_strap_in};

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
        end else begin
            sync1_q <= raw_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            // a bit moves only once stages two and three agree
            filt_q <= (sync2_q & ~(sync2_q ^ sync3_q))
                    | (filt_q & (sync2_q ^ sync3_q));
        end
    end

    // straps are caught once, after the filter has settled
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            settle_q <= 3'h0;
            strap_done_q <= 1'b0;
            sel_q <= 2'h3;
        end else if (!strap_done_q) begin
            settle_q <= 3'(settle_q + 3'h1);
            if (settle_q == IMW_STRAP_SETTLE) begin
                strap_done_q <= 1'b1;
                sel_q <= {filt_q[1], filt_q[0]};
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            osc_sync_pin_oe_out <= 1'b0;
            osc_sync_pin_out <= 1'b0;
            ext_sync_out <= 1'b0;
        end else begin
            osc_sync_pin_oe_out <= strap_done_q && sel_q[1];
            osc_sync_pin_out <= osc_ref_in;
            ext_sync_out <= strap_done_q && !sel_q[1] && filt_q[2];
        end
    end

    // ---------------- link domain
    // start and stop seen on data edges while clock is high
    always_ff @(negedge sda_in or posedge reset_in) begin
        if (reset_in) begin
            start_tog_q <= 1'b0;
        end else if (scl_in) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge sda_in or posedge reset_in) begin
        if (reset_in) begin
            stop_tog_q <= 1'b0;
        end else if (scl_in) begin
            stop_tog_q <= ~stop_tog_q;
        end
    end

    // strap bits are static after reset; two stages suffice
    always_ff @(posedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            sel_m_q <= 2'h3;
            sel_s_q <= 2'h3;
        end else begin
            sel_m_q <= sel_q;
            sel_s_q <= sel_m_q;
        end
    end

    // start toggle is read on the next low edge; bus hold time
    // after a start covers its settling
    always_ff @(negedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            start_seen_q <= 1'b0;
            start_hit_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else begin
            start_seen_q <= start_tog_q;
            start_hit_q <= start_tog_q != start_seen_q;
            ack_drive_q <= (start_tog_q == start_seen_q) && ack_q
                         && (bit_cnt_q == IMW_ACK_BIT);
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = ack_drive_q;

    assign byte_w = {shift_q, sda_in};
    assign addr_match = (byte_w[7:1] == {IMW_ADDR_FIXED, sel_s_q})
                      && !byte_w[0];

    always_ff @(posedge scl_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= LNK_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
            ack_q <= 1'b0;
            evt_q <= '0;
            evt_tog_q <= 1'b0;
        end else if (start_hit_q) begin
            state_q <= LNK_ADDR;
            bit_cnt_q <= 4'h1;
            shift_q <= {6'h00, sda_in};
            ack_q <= 1'b0;
            evt_q <= '{is_start: 1'b1, data: 8'h00};
            evt_tog_q <= ~evt_tog_q;
        end else begin
            case (state_q)
                LNK_ADDR, LNK_DATA: begin
                    if (bit_cnt_q == IMW_ACK_BIT) begin
                        bit_cnt_q <= 4'h0;
                        ack_q <= 1'b0;
                        state_q <= ack_q ? LNK_DATA : LNK_IDLE;
                    end else begin
                        shift_q <= byte_w[6:0];
                        bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
                        if (bit_cnt_q == IMW_LAST_BIT) begin
                            ack_q <= (state_q == LNK_DATA) || addr_match;
                            if (state_q == LNK_DATA) begin
                                evt_q <= '{is_start: 1'b0, data: byte_w};
                                evt_tog_q <= ~evt_tog_q;
                            end
                        end
                    end
                end
                default: begin
                    ack_q <= 1'b0;
                end
            endcase
        end
    end

    // ---------------- system domain: command decode
    // evt_q holds for a whole byte time, far past the filter delay
    assign evt_new = filt_q[4] != evt_seen_q;
    assign stop_new = filt_q[3] != stop_seen_q;
    assign fld = evt_q.data[7:5];
    assign val = evt_q.data[4:0];
    assign is_byte = evt_new && !evt_q.is_start;
    assign is_guard = val == IMW_VAL_GUARD;
    assign mar_cmd = is_byte && fld == IMW_FLD_MARGIN && !is_guard
                   && guard_q == GRD_MARGIN
                   && val[3:0] != IMW_MARGIN_UNDEF;
    assign sup_cmd = is_byte && fld == IMW_FLD_SUP && !is_guard
                   && guard_q == GRD_SUP && val[4:3] == IMW_SUP_EN_CODE;
    // while the timer is enabled in window mode, only an open window accepts a command
    assign sup_ok = sup_cmd
                  && (!sup_q.enable || !sup_q.window || sup_window_open_in);
    assign sup_off = is_byte && fld == IMW_FLD_SUP && is_guard
                   && guard_q == GRD_SUP;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            evt_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            bus_active_out <= 1'b0;
        end else begin
            evt_seen_q <= filt_q[4];
            stop_seen_q <= filt_q[3];
            // stop returns to idle, a start wins
            if (evt_new && evt_q.is_start) begin
                bus_active_out <= 1'b1;
            end else if (stop_new) begin
                bus_active_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            guard_q <= GRD_NONE;
        end else if (evt_new) begin
            if (evt_q.is_start) begin
                guard_q <= GRD_NONE;
            end else begin
                case (fld)
                    IMW_FLD_MARGIN: begin
                        if (is_guard || guard_q == GRD_MARGIN) begin
                            guard_q <= GRD_MARGIN;
                        end else begin
                            guard_q <= GRD_NONE;
                        end
                    end
                    // a second guard in a row disarms
                    IMW_FLD_SUP: begin
                        if (is_guard && guard_q != GRD_SUP) begin
                            guard_q <= GRD_SUP;
                        end else begin
                            guard_q <= GRD_NONE;
                        end
                    end
                    default: begin
                        guard_q <= GRD_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            linear_margin_out <= IMW_MARGIN_NOMINAL;
            switching_margin_out <= IMW_MARGIN_NOMINAL;
        end else if (mar_cmd) begin
            if (val[IMW_TGT_BIT]) begin
                switching_margin_out <= val[3:0];
            end else begin
                linear_margin_out <= val[3:0];
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sup_q <= '{enable: 1'b0, window: 1'b0, period: IMW_PERIOD_RST};
            sup_restart_out <= 1'b0;
        end else begin
            sup_restart_out <= sup_ok;
            if (sup_ok) begin
                sup_q <= '{enable: 1'b1, window: val[IMW_WIN_BIT],
                           period: val[1:0]};
            end else if (sup_off) begin
                sup_q.enable <= 1'b0;
            end
        end
    end

    assign sup_cfg_out = sup_q;

    // ---------------- checks
    AST_ADDR_FIXED: assert property (
        @(posedge scl_in) disable iff (reset_in)
        (state_q == LNK_ADDR && bit_cnt_q == IMW_ACK_BIT && ack_q)
        |-> shift_q[6:3] == IMW_ADDR_FIXED[3:0])
        else $error("address acked with wrong fixed bits");
    AST_ADDR_STRAP: assert property (
        @(posedge scl_in) disable iff (reset_in)
        (state_q == LNK_ADDR && bit_cnt_q == IMW_ACK_BIT && ack_q)
        |-> shift_q[2:1] == sel_s_q && !shift_q[0])
        else $error("address acked with wrong strap bits");
    AST_ACK_ONE_BIT: assert property (
        @(negedge scl_in) disable iff (reset_in)
        ack_drive_q |=> !ack_drive_q)
        else $error("acknowledge held past one bit");
    AST_OSC_PIN: assert property (
        @(posedge clk_in) disable iff (reset_in)
        strap_done_q ##1 strap_done_q |-> osc_sync_pin_oe_out == sel_q[1])
        else $error("sync pin direction disagrees with strap");
    AST_MARGIN_SET: assert property (
        @(posedge clk_in) disable iff (reset_in)
        mar_cmd && !val[IMW_TGT_BIT] |=> linear_margin_out ==
        $past(val[3:0]) && $stable(switching_margin_out))
        else $error("linear margin not taken");
    AST_MARGIN_GUARD: assert property (
        @(posedge clk_in) disable iff (reset_in)
        is_byte && guard_q != GRD_MARGIN
        |=> $stable(linear_margin_out) && $stable(switching_margin_out))
        else $error("unguarded margin byte changed output");
    AST_SUP_ON: assert property (
        @(posedge clk_in) disable iff (reset_in)
        sup_ok |=> sup_cfg_out.enable && sup_restart_out
        && sup_cfg_out.period == $past(val[1:0]) ##1 !sup_restart_out)
        else $error("timer command not applied");
    AST_SUP_OFF: assert property (
        @(posedge clk_in) disable iff (reset_in)
        sup_off |=> !sup_cfg_out.enable && guard_q == GRD_NONE)
        else $error("double guard did not stop timer");
    AST_SUP_WINDOW: assert property (
        @(posedge clk_in) disable iff (reset_in)
        sup_cmd && sup_q.enable && sup_q.window && !sup_window_open_in
        |=> !sup_restart_out && $stable(sup_cfg_out))
        else $error("closed window accepted a command");
    AST_STOP_IDLE: assert property (
        @(posedge clk_in) disable iff (reset_in)
        stop_new && !(evt_new && evt_q.is_start) |=> !bus_active_out)
        else $error("stop did not end the transfer");
    COV_MARGIN_BOTH: cover property (@(posedge clk_in)
        mar_cmd && val[IMW_TGT_BIT] ##[1:400] mar_cmd
        && !val[IMW_TGT_BIT]);
    COV_SUP_ON: cover property (@(posedge clk_in) sup_ok);
    COV_SUP_OFF: cover property (@(posedge clk_in) sup_off);
endmodule

/* File: verification/imw_host_model.sv */
// two-wire bus master model that drives the serial clock only in frames
module imw_host_model (
    output logic scl_out, // serial clock to the slave
    output logic sda_low_out, // high pulls the data wire low
    input wire logic sda_in // resolved data wire level
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 80;
    localparam int SETUP = 20;

    // clock parks high between frames, data released to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // data falls while the clock is high
    task automatic bus_start();
        sda_low_out = 1'b0;
        scl_out = 1'b1;
        #HALF sda_low_out = 1'b1;
        #HALF scl_out = 1'b0;
    endtask

    // data rises while the clock is high
    task automatic bus_stop();
        #SETUP sda_low_out = 1'b1;
        #(HALF - SETUP) scl_out = 1'b1;
        #HALF sda_low_out = 1'b0;
        #HALF;
    endtask

    // msb first; data moves well after the falling edge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #SETUP sda_low_out = ~b[i];
            #(HALF - SETUP) scl_out = 1'b1;
            #HALF scl_out = 1'b0;
        end
        #SETUP sda_low_out = 1'b0;
        #(HALF - SETUP) scl_out = 1'b1;
        ack = ~sda_in;
        #HALF scl_out = 1'b0;
    endtask
endmodule

/* File: verification/testbench.sv */
// self-checking bench of the margin and supervision command slave
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import imw_pkg::*;
    logic clk_in, reset_in, scl, host_low, sda_oe, sda_drv, sda_wire;
    logic mode_strap, addr_strap, osc_ref, osc_drv, osc_out, osc_oe;
    logic osc_pin, ext_sync, restart, window_open, bus_active;
    logic [3:0] lin_margin, sw_margin;
    logic [7:0] seed;
    imw_sup_type sup_cfg;
    int err_total, checks, restarts;

    // open drain wire with pull-up
    assign sda_wire = ~((sda_oe & ~sda_drv) | host_low);
    assign osc_pin = osc_oe ? osc_out : osc_drv;

    imw_slave u_imw_slave (
        .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .oscillator_mode_strap_in(mode_strap), .addr_strap_in(addr_strap),
        .osc_ref_in(osc_ref), .osc_sync_pin_in(osc_pin),
        .osc_sync_pin_out(osc_out), .osc_sync_pin_oe_out(osc_oe),
        .ext_sync_out(ext_sync), .linear_margin_out(lin_margin),
        .switching_margin_out(sw_margin), .sup_cfg_out(sup_cfg),
        .sup_restart_out(restart), .sup_window_open_in(window_open),
        .bus_active_out(bus_active)
    );
    imw_host_model u_imw_host_model (
        .scl_out(scl), .sda_low_out(host_low), .sda_in(sda_wire)
    );

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (restart === 1'b1) restarts++;
    end
    always @(negedge clk_in) begin
        osc_ref <= osc_ref ^ seed[3];
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic imw_sup_type sup_exp(input logic [4:0] v);
        return '{enable: 1'b1, window: v[IMW_WIN_BIT], period: v[1:0]};
    endfunction

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // straps are caught only after a reset release
    task automatic do_reset(input logic m, input logic a);
        @(negedge clk_in);
        mode_strap = m;
        addr_strap = a;
        reset_in = 1'b1;
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (12) @(negedge clk_in);
    endtask
    task automatic probe(input logic [7:0] a, input logic exp);
        logic ack;
        u_imw_host_model.bus_start();
        u_imw_host_model.put_byte(a, ack);
        repeat (2) @(negedge clk_in);
        check("bus active", {7'h0, bus_active}, 8'h01);
        u_imw_host_model.bus_stop();
        repeat (8) @(negedge clk_in);
        check("address ack", {7'h0, ack}, {7'h0, exp});
        check("bus idle", {7'h0, bus_active}, 8'h00);
    endtask
    task automatic xfer(input logic [7:0] b0, b1, b2, input int n);
        logic [7:0] bytes [3];
        logic ack;
        bytes = '{b0, b1, b2};
        u_imw_host_model.bus_start();
        u_imw_host_model.put_byte({IMW_ADDR_FIXED, mode_strap,
                                   addr_strap, 1'b0}, ack);
        check("address ack", {7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_imw_host_model.put_byte(bytes[i], ack);
            check("data ack", {7'h0, ack}, 8'h01);
        end
        u_imw_host_model.bus_stop();
        repeat (8) @(negedge clk_in);
    endtask
    task automatic chk_margin(input logic [3:0] lin, input logic [3:0] sw);
        check("linear margin", {4'h0, lin_margin}, {4'h0, lin});
        check("switching margin", {4'h0, sw_margin}, {4'h0, sw});
    endtask
    // restart delta is judged only when every field is compared
    task automatic sup_step(input logic [7:0] b0, b1, input logic win,
                            input logic [3:0] exp, m, input int d);
        int r0;
        window_open = win;
        r0 = restarts;
        xfer(b0, b1, 8'h00, 2);
        check("timer settings", {4'h0, sup_cfg & m}, {4'h0, exp & m});
        if (m == 4'hf) check("restarts", 8'(restarts - r0), 8'(d));
    endtask

    initial begin
        repeat (100000) @(posedge clk_in);
        err_total++;
        $display("Error run limit expected finish seen hang");
        give_verdict();
    end

    initial begin
        logic [3:0] code, lin_exp, sw_exp;
        logic tgt;
        logic [15:0] bad [4];
        reset_in = 1'b1;
        mode_strap = 1'b1;
        addr_strap = 1'b1;
        osc_ref = 1'b0;
        osc_drv = 1'b0;
        window_open = 1'b1;
        err_total = 0;
        checks = 0;
        restarts = 0;
        seed = 8'h1d;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1], i[0]);
            check("sync pin oe", {7'h0, osc_oe}, {7'h0, i[1]});
            check("sync pin out", {7'h0, osc_out}, {7'h0, osc_ref});
            osc_drv = 1'b1;
            repeat (6) @(negedge clk_in);
            check("ext sync", {7'h0, ext_sync}, {7'h0, ~i[1]});
            osc_drv = 1'b0;
            probe({IMW_ADDR_FIXED, i[1:0], 1'b0}, 1'b1);
            probe({IMW_ADDR_FIXED, ~i[1:0], 1'b0}, 1'b0);
            probe({5'h1c, i[1:0], 1'b0}, 1'b0);
            probe({IMW_ADDR_FIXED, i[1:0], 1'b1}, 1'b0);
        end
        $display("address and strap test done");
        // both outputs behind one guard, extreme codes
        xfer(8'h20, 8'h3e, 8'h27, 3);
        lin_exp = 4'h7;
        sw_exp = 4'he;
        chk_margin(lin_exp, sw_exp);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            tgt = seed[4];
            code = seed[3:0];
            // linear nominal would look like the guard byte itself
            if (code == 4'hf || (code == 4'h0 && !tgt)) code = 4'h1;
            xfer(8'h20, {3'h1, tgt, code}, 8'h00, 2);
            if (tgt) sw_exp = code;
            else lin_exp = code;
            chk_margin(lin_exp, sw_exp);
        end
        bad = '{16'h2500, 16'ha0a3, 16'h202f, 16'h6025};
        for (int k = 0; k < 4; k++) begin
            xfer(bad[k][15:8], bad[k][7:0], 8'h00, 2);
            chk_margin(lin_exp, sw_exp);
        end
        $display("margining test done");
        for (int k = 0; k < 8; k++) begin
            sup_step(8'h60, {5'h0d, k[2:0]}, 1'b1,
                     sup_exp({2'h1, k[2:0]}), 4'hf, 1);
        end
        sup_step(8'h60, 8'h69, 1'b0, 4'hf, 4'hf, 0);
        sup_step(8'h60, 8'h69, 1'b1, 4'h9, 4'hf, 1);
        sup_step(8'h60, 8'h70, 1'b1, 4'h9, 4'hf, 0);
        sup_step(8'h60, 8'h60, 1'b1, 4'h0, 4'h8, 0);
        sup_step(8'h6b, 8'h00, 1'b1, 4'h0, 4'h8, 0);
        sup_step(8'h60, 8'h6a, 1'b1, 4'ha, 4'hf, 1);
        $display("supervision test done");
        give_verdict();
    end
endmodule
